// ==== core/stdc_consts.svh ====
// Constants for the stepper translator and decay control block
`ifndef STDC_CONSTS_SVH
`define STDC_CONSTS_SVH

`define STDC_CLK_NS 20
`define STDC_FIXED_OFF_TIME_NS 30000
`define STDC_BLANK_NS 1000
`define STDC_FAST_PCT_X100 3125
`define STDC_FIXED_OFF_TIME_CYC (`STDC_FIXED_OFF_TIME_NS / `STDC_CLK_NS)
`define STDC_FAST_CYC ((`STDC_FIXED_OFF_TIME_CYC * `STDC_FAST_PCT_X100) / 10000)
`define STDC_BLANK_CYC (`STDC_BLANK_NS / `STDC_CLK_NS)
`define STDC_CNT_W 11
`define STDC_HOME_POS 3'h1
`define STDC_HALF_DELTA 3'h1
`define STDC_FULL_DELTA 3'h2
`define STDC_MAG_ZERO 2'h0
`define STDC_MAG_MID 2'h1
`define STDC_MAG_FULL 2'h2
`define STDC_BOTH_MIXED 2'h3
`define STDC_GATES_OFF 4'h0

`endif

// ==== core/stdc_pkg.sv ====
// Types shared by the stepper translator and decay control block
package stdc_pkg;

    typedef struct packed {
        logic src_a;
        logic sink_a;
        logic src_b;
        logic sink_b;
    } stdc_gates_t;

    typedef struct packed {
        logic neg;
        logic [1:0] mag;
    } stdc_level_t;

    typedef struct packed {
        logic step;
        logic dir;
        logic res;
        logic dis;
        logic nchip_rst;
        logic reg_fault;
        logic cp_uv;
        logic overtemp;
        logic undervoltage_lockout;
        logic [1:0] trip;
        logic [1:0] zero;
    } stdc_pins_t;

    typedef enum logic [1:0] {
        ST_DRIVE,
        ST_FAST,
        ST_SLOW
    } stdc_phase_t;

endpackage

// ==== core/stdc_bridge_if.sv ====
// Carrier between the translator and one full-bridge chopper
`timescale 1ns/1ps
interface stdc_bridge_if;
    import stdc_pkg::*;
    logic en;
    logic positive;
    logic active;
    logic mixed;
    logic trip;
    logic zero;
    stdc_gates_t gates;

    modport ctrl (output en, positive, active, mixed, trip, zero, input gates);
    modport drv (input en, positive, active, mixed, trip, zero, output gates);
endinterface

// ==== core/stdc_bridge.sv ====
// Fixed off-time chopper with decay sequencing for one full bridge
`timescale 1ns/1ps
`include "stdc_consts.svh"
module stdc_bridge
    import stdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    stdc_bridge_if.drv br
);
    stdc_phase_t state_reg, state_next;
    logic [`STDC_CNT_W-1:0] cnt_reg, cnt_next;
    logic zs_reg, zs_next;
    stdc_gates_t gates_reg, gates_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        zs_next = zs_reg;
        if (!br.en || !br.active) begin
            state_next = ST_DRIVE;
            cnt_next = '0;
            zs_next = 1'b0;
        end else begin
            case (state_reg)
                ST_DRIVE: begin
                    // Blanking hides switching spikes from the comparator
                    if (cnt_reg < `STDC_CNT_W'(`STDC_BLANK_CYC)) begin
                        cnt_next = cnt_reg + 1'b1;
                    end else if (br.trip) begin
                        state_next = br.mixed ? ST_FAST : ST_SLOW;
                        cnt_next = '0;
                        zs_next = 1'b0;
                    end
                end
                ST_FAST, ST_SLOW: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (br.zero) begin
                        zs_next = 1'b1;
                    end
                    if (state_reg == ST_FAST
                        && cnt_reg == `STDC_CNT_W'(`STDC_FAST_CYC - 1)) begin
                        state_next = ST_SLOW;
                    end
                    if (cnt_reg == `STDC_CNT_W'(`STDC_FIXED_OFF_TIME_CYC - 1)) begin
                        state_next = ST_DRIVE;
                        cnt_next = '0;
                    end
                end
                default: begin
                    state_next = ST_DRIVE;
                    cnt_next = '0;
                end
            endcase
        end
        gates_next = `STDC_GATES_OFF;
        if (br.en && br.active) begin
            case (state_next)
                ST_DRIVE: begin
                    gates_next.src_a = br.positive;
                    gates_next.sink_b = br.positive;
                    gates_next.src_b = !br.positive;
                    gates_next.sink_a = !br.positive;
                end
                ST_FAST: begin
                    // Reverse diagonal conducts instead of the body diodes
                    gates_next.src_b = br.positive && !zs_next;
                    gates_next.sink_a = br.positive && !zs_next;
                    gates_next.src_a = !br.positive && !zs_next;
                    gates_next.sink_b = !br.positive && !zs_next;
                end
                ST_SLOW: begin
                    gates_next.sink_a = !zs_next;
                    gates_next.sink_b = !zs_next;
                end
                default: gates_next = `STDC_GATES_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= ST_DRIVE;
            cnt_reg <= '0;
            zs_reg <= 1'b0;
            gates_reg <= `STDC_GATES_OFF;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            zs_reg <= zs_next;
            gates_reg <= gates_next;
        end
    end

    assign br.gates = gates_reg;

    property p_fast_len;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == ST_FAST) |-> (cnt_reg < `STDC_CNT_W'(`STDC_FAST_CYC));
    endproperty
    a_fast_len: assert property (p_fast_len) else $error("Fast decay too long");

    property p_zero_off;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg != ST_DRIVE && state_next != ST_DRIVE && zs_next)
            |=> (gates_reg == `STDC_GATES_OFF);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("Rectifier on after zero");

    property p_slow_sinks;
        @(posedge clk_i) disable iff (!nrst_i)
        (br.en && br.active && state_next == ST_SLOW && !zs_next)
            |=> (gates_reg.sink_a && gates_reg.sink_b && !gates_reg.src_a && !gates_reg.src_b);
    endproperty
    a_slow_sinks: assert property (p_slow_sinks) else $error("Slow decay gates wrong");

    property p_drive_diag;
        @(posedge clk_i) disable iff (!nrst_i)
        (br.en && br.active && state_next == ST_DRIVE && br.positive)
            |=> (gates_reg.src_a && gates_reg.sink_b && !gates_reg.src_b);
    endproperty
    a_drive_diag: assert property (p_drive_diag) else $error("Drive diagonal wrong");
endmodule

// ==== core/stdc_top.sv ====
// Stepper translator with output gating and per-bridge decay control
`timescale 1ns/1ps
`include "stdc_consts.svh"
module stdc_top
    import stdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic step_resolution_select_i,
    input wire logic output_disable_i,
    input wire logic nchip_reset_i,
    input wire logic sink_gate_regulator_fault_i,
    input wire logic charge_pump_reservoir_uv_i,
    input wire logic overtemp_i,
    input wire logic undervoltage_lockout_i,
    input wire logic [1:0] trip_i,
    input wire logic [1:0] zero_i,
    output stdc_gates_t bridge1_gates_o,
    output stdc_gates_t bridge2_gates_o,
    output logic [2:0] position_o,
    output stdc_level_t level1_o,
    output stdc_level_t level2_o,
    output logic [1:0] mixed_decay_o,
    output logic outputs_enabled_o
);
    localparam int PW = $bits(stdc_pins_t);

    logic [PW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [PW-1:0] s1_next, s2_next, s3_next, filt_next;
    stdc_pins_t raw, pin;
    logic step_prev_reg, step_prev_next;
    logic [2:0] pos_reg, pos_next;
    logic [1:0] mixed_reg, mixed_next;
    logic en_reg, en_next;
    stdc_level_t lv1_reg, lv1_next, lv2_reg, lv2_next;
    logic hold, step_edge;
    logic [2:0] delta;

    stdc_bridge_if br [2] ();

    // Signed phase currents for each table entry
    function automatic stdc_level_t phase_level(input logic [2:0] p, input logic second);
        stdc_level_t l;
        l = '0;
        case (p)
            3'h0: l = second ? '{1'b0, `STDC_MAG_ZERO} : '{1'b0, `STDC_MAG_FULL};
            3'h1: l = '{1'b0, `STDC_MAG_MID};
            3'h2: l = second ? '{1'b0, `STDC_MAG_FULL} : '{1'b0, `STDC_MAG_ZERO};
            3'h3: l = second ? '{1'b0, `STDC_MAG_MID} : '{1'b1, `STDC_MAG_MID};
            3'h4: l = second ? '{1'b0, `STDC_MAG_ZERO} : '{1'b1, `STDC_MAG_FULL};
            3'h5: l = '{1'b1, `STDC_MAG_MID};
            3'h6: l = second ? '{1'b1, `STDC_MAG_FULL} : '{1'b0, `STDC_MAG_ZERO};
            3'h7: l = second ? '{1'b1, `STDC_MAG_MID} : '{1'b0, `STDC_MAG_MID};
            default: l = '0;
        endcase
        return l;
    endfunction

    assign raw = '{step_i, dir_i, step_resolution_select_i, output_disable_i,
                   nchip_reset_i, sink_gate_regulator_fault_i,
                   charge_pump_reservoir_uv_i, overtemp_i, undervoltage_lockout_i,
                   trip_i, zero_i};
    assign pin = stdc_pins_t'(filt_reg);

    // Power-on lockout and the reset pin share one hold path
    assign hold = !pin.nchip_rst || pin.undervoltage_lockout;
    assign step_edge = pin.step && !step_prev_reg && !hold;
    assign delta = pin.res ? `STDC_HALF_DELTA : `STDC_FULL_DELTA;

    always_comb begin
        s1_next = PW'(raw);
        s2_next = s1_reg;
        s3_next = s2_reg;
        // A bit moves only when stages two and three agree
        filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
        step_prev_next = pin.step;
        pos_next = pos_reg;
        mixed_next = mixed_reg;
        if (hold) begin
            pos_next = `STDC_HOME_POS;
            mixed_next = `STDC_BOTH_MIXED;
        end else if (step_edge) begin
            // Direction only matters here, so mid-step changes are ignored
            pos_next = pin.dir ? pos_reg + delta : pos_reg - delta;
        end
        lv1_next = phase_level(pos_next, 1'b0);
        lv2_next = phase_level(pos_next, 1'b1);
        if (!hold && step_edge) begin
            mixed_next[0] = lv1_next.mag < lv1_reg.mag;
            mixed_next[1] = lv2_next.mag < lv2_reg.mag;
        end
        en_next = !pin.dis && !pin.reg_fault && !pin.cp_uv && !pin.overtemp
                  && !hold;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
            step_prev_reg <= 1'b0;
            pos_reg <= `STDC_HOME_POS;
            mixed_reg <= `STDC_BOTH_MIXED;
            en_reg <= 1'b0;
            lv1_reg <= '{1'b0, `STDC_MAG_MID};
            lv2_reg <= '{1'b0, `STDC_MAG_MID};
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            filt_reg <= filt_next;
            step_prev_reg <= step_prev_next;
            pos_reg <= pos_next;
            mixed_reg <= mixed_next;
            en_reg <= en_next;
            lv1_reg <= lv1_next;
            lv2_reg <= lv2_next;
        end
    end

    // Bridge enables see the combined gate so a fault clears the gates next edge
    assign br[0].en = en_next;
    assign br[0].positive = !lv1_reg.neg;
    assign br[0].active = lv1_reg.mag != `STDC_MAG_ZERO;
    assign br[0].mixed = mixed_reg[0];
    assign br[0].trip = pin.trip[0];
    assign br[0].zero = pin.zero[0];
    assign br[1].en = en_next;
    assign br[1].positive = !lv2_reg.neg;
    assign br[1].active = lv2_reg.mag != `STDC_MAG_ZERO;
    assign br[1].mixed = mixed_reg[1];
    assign br[1].trip = pin.trip[1];
    assign br[1].zero = pin.zero[1];

    stdc_bridge u_bridge1 (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .br(br[0])
    );

    stdc_bridge u_bridge2 (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .br(br[1])
    );

    assign bridge1_gates_o = br[0].gates;
    assign bridge2_gates_o = br[1].gates;
    assign position_o = pos_reg;
    assign level1_o = lv1_reg;
    assign level2_o = lv2_reg;
    assign mixed_decay_o = mixed_reg;
    assign outputs_enabled_o = en_reg;

    property p_reg_fault_off;
        @(posedge clk_i) disable iff (!nrst_i)
        pin.reg_fault |=> (bridge1_gates_o == `STDC_GATES_OFF
                           && bridge2_gates_o == `STDC_GATES_OFF);
    endproperty
    a_reg_fault_off: assert property (p_reg_fault_off) else $error("Gates on in fault");

    property p_disable_off;
        @(posedge clk_i) disable iff (!nrst_i)
        pin.dis |=> (bridge1_gates_o == `STDC_GATES_OFF && !outputs_enabled_o);
    endproperty
    a_disable_off: assert property (p_disable_off) else $error("Gates on when disabled");

    property p_shutdown_off;
        @(posedge clk_i) disable iff (!nrst_i)
        (pin.overtemp || pin.cp_uv) |=> (bridge2_gates_o == `STDC_GATES_OFF);
    endproperty
    a_shutdown_off: assert property (p_shutdown_off) else $error("Gates on in shutdown");

    property p_undervoltage_lockout_home;
        @(posedge clk_i) disable iff (!nrst_i)
        pin.undervoltage_lockout |=> (position_o == `STDC_HOME_POS && !outputs_enabled_o);
    endproperty
    a_undervoltage_lockout_home: assert property (p_undervoltage_lockout_home) else $error("Lockout not at home");

    property p_reset_home;
        @(posedge clk_i) disable iff (!nrst_i)
        (!pin.nchip_rst && pin.step) |=> (position_o == `STDC_HOME_POS
                                          && mixed_decay_o == `STDC_BOTH_MIXED);
    endproperty
    a_reset_home: assert property (p_reset_home) else $error("Reset not holding home");

    property p_step_dis;
        @(posedge clk_i) disable iff (!nrst_i)
        (step_edge && pin.dis && pin.res && pin.dir)
            |=> (position_o == $past(pos_reg) + `STDC_HALF_DELTA);
    endproperty
    a_step_dis: assert property (p_step_dis) else $error("No advance while disabled");

    property p_full_step;
        @(posedge clk_i) disable iff (!nrst_i)
        (step_edge && !pin.res && !pin.dir)
            |=> (position_o == $past(pos_reg) - `STDC_FULL_DELTA);
    endproperty
    a_full_step: assert property (p_full_step) else $error("Full step wrong");

    property p_no_step_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (!step_edge && !hold) |=> $stable(position_o);
    endproperty
    a_no_step_hold: assert property (p_no_step_hold) else $error("Moved without step");

    property p_decay_sel;
        @(posedge clk_i) disable iff (!nrst_i)
        step_edge |=> (mixed_decay_o[0] == (level1_o.mag < $past(lv1_reg.mag)));
    endproperty
    a_decay_sel: assert property (p_decay_sel) else $error("Decay select wrong");
endmodule

// ==== verif/stdc_host_model.sv ====
// Host-side model that issues step pulses to the translator
`timescale 1ns/1ps
module stdc_host_model (
    input wire logic clk_i,
    output logic step_o
);
    initial step_o = 1'b0;

    // Six clocks high and six low, so each phase clears the four-stage input filter
    task automatic do_step();
        @(posedge clk_i);
        #1 step_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 step_o = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
endmodule

// ==== verif/stepper_translator_decay_control_bench.sv ====
// Self-checking bench for the stepper translator and decay control block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module stepper_translator_decay_control_bench
    import stdc_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic step_w;
    logic dir_r = 1'b1;
    logic res_r = 1'b1;
    logic dis_r = 1'b0;
    logic nchip_r = 1'b1;
    logic [2:0] flt_r = 3'h0;
    logic undervoltage_lockout_r = 1'b0;
    logic [1:0] trip_r = 2'h0;
    logic [1:0] zero_r = 2'h0;
    stdc_gates_t g1;
    stdc_gates_t g2;
    logic [2:0] pos_o;
    stdc_level_t lv1_o;
    stdc_level_t lv2_o;
    logic [1:0] mix_o;
    logic en_o;
    int mismatches = 0;
    int num_checks = 0;
    logic [2:0] pos = 3'h1;
    // Expected {neg, mag} per table entry; a zero level is compared on magnitude only
    logic [2:0] lv1_tab [8] = '{3'h2, 3'h1, 3'h0, 3'h5, 3'h6, 3'h5, 3'h0, 3'h1};
    logic [2:0] lv2_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h5, 3'h6, 3'h5};

    always #10 clk_i = ~clk_i;

    stdc_host_model stdc_host_model_i (.clk_i(clk_i), .step_o(step_w));

    stdc_top stdc_top_i (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .step_i(step_w),
        .dir_i(dir_r),
        .step_resolution_select_i(res_r),
        .output_disable_i(dis_r),
        .nchip_reset_i(nchip_r),
        .sink_gate_regulator_fault_i(flt_r[0]),
        .charge_pump_reservoir_uv_i(flt_r[1]),
        .overtemp_i(flt_r[2]),
        .undervoltage_lockout_i(undervoltage_lockout_r),
        .trip_i(trip_r),
        .zero_i(zero_r),
        .bridge1_gates_o(g1),
        .bridge2_gates_o(g2),
        .position_o(pos_o),
        .level1_o(lv1_o),
        .level2_o(lv2_o),
        .mixed_decay_o(mix_o),
        .outputs_enabled_o(en_o)
    );

    function automatic logic [2:0] msk(input logic [2:0] x);
        return (x[1:0] === 2'h0) ? 3'h0 : x;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_off();
        `CHK(en_o, 1'b0)
        `CHK({g2, g1}, 8'h00)
    endtask

    // One host step, then position, levels and decay choice against the table
    task automatic step_chk(input logic d, input logic r, input logic moves);
        logic [2:0] nxt;
        logic [1:0] mx;
        nxt = d ? pos + (r ? 3'h1 : 3'h2) : pos - (r ? 3'h1 : 3'h2);
        if (!moves) nxt = pos;
        mx = {lv2_tab[nxt][1:0] < lv2_tab[pos][1:0], lv1_tab[nxt][1:0] < lv1_tab[pos][1:0]};
        dir_r = d;
        res_r = r;
        cyc(6);
        stdc_host_model_i.do_step();
        `CHK(pos_o, nxt)
        `CHK(msk(lv1_o), msk(lv1_tab[nxt]))
        `CHK(msk(lv2_o), msk(lv2_tab[nxt]))
        if (moves) `CHK(mix_o, mx)
        pos = nxt;
    endtask

    // Both bridges at home: positive drive, mixed decay, timed off-phase
    task automatic chopper();
        int n;
        // Let the on-phase blanking run out first, or the trip is hidden
        cyc(60);
        trip_r = 2'h3;
        n = 0;
        while ({g2, g1} !== 8'h66 && n < 10) begin
            cyc(1);
            n++;
        end
        trip_r = 2'h0;
        `CHK(n, 5)
        n = 0;
        while ({g2, g1} === 8'h66 && n < 2000) begin
            cyc(1);
            n++;
        end
        `CHK(n, 468)
        `CHK({g2, g1}, 8'h55)
        n = 0;
        while ({g2, g1} === 8'h55 && n < 2000) begin
            cyc(1);
            n++;
        end
        `CHK(n, 1032)
        `CHK({g2, g1}, 8'h99)
    endtask

    // Zero current in the fast phase drops every gate until the off-time ends
    task automatic zero_stop();
        cyc(60);
        trip_r = 2'h3;
        cyc(6);
        trip_r = 2'h0;
        `CHK({g2, g1}, 8'h66)
        zero_r = 2'h3;
        cyc(6);
        `CHK({g2, g1}, 8'h00)
        zero_r = 2'h0;
        cyc(300);
        `CHK({g2, g1}, 8'h00)
        cyc(1300);
        `CHK({g2, g1}, 8'h99)
    endtask

    task automatic gating();
        dis_r = 1'b1;
        cyc(6);
        chk_off();
        step_chk(1'b1, 1'b1, 1'b1);
        dis_r = 1'b0;
        cyc(6);
        `CHK(en_o, 1'b1)
        for (int i = 0; i < 3; i++) begin
            flt_r = 3'h1 << i;
            cyc(6);
            chk_off();
            flt_r = 3'h0;
            cyc(6);
            `CHK(en_o, 1'b1)
        end
        undervoltage_lockout_r = 1'b1;
        cyc(6);
        chk_off();
        pos = 3'h1;
        `CHK(pos_o, 3'h1)
        `CHK(mix_o, 2'h3)
        undervoltage_lockout_r = 1'b0;
        cyc(6);
    endtask

    // Rising level on bridge 1 selects slow decay: sinks only for the whole off-time
    task automatic slow_chop();
        int n;
        step_chk(1'b0, 1'b1, 1'b1);
        `CHK(mix_o, 2'h2)
        cyc(60);
        trip_r = 2'h1;
        n = 0;
        while ({g2, g1} !== 8'h95 && n < 10) begin
            cyc(1);
            n++;
        end
        trip_r = 2'h0;
        `CHK(n, 5)
        n = 0;
        while ({g2, g1} === 8'h95 && n < 2000) begin
            cyc(1);
            n++;
        end
        `CHK(n, 1500)
        `CHK({g2, g1}, 8'h99)
    endtask

    // Reset pin holds home and swallows steps; a rise seen while held is lost
    task automatic chip_reset();
        step_chk(1'b1, 1'b1, 1'b1);
        nchip_r = 1'b0;
        cyc(6);
        chk_off();
        `CHK(pos_o, 3'h1)
        pos = 3'h1;
        step_chk(1'b1, 1'b1, 1'b0);
        nchip_r = 1'b1;
        cyc(6);
        step_chk(1'b1, 1'b1, 1'b1);
    endtask

    initial begin
        cyc(4);
        `CHK({g2, g1}, 8'h00)
        `CHK(pos_o, 3'h1)
        `CHK(lv1_o, 3'h1)
        `CHK(lv2_o, 3'h1)
        `CHK(mix_o, 2'h3)
        `CHK(en_o, 1'b0)
        nrst_i = 1'b1;
        cyc(10);
        `CHK(en_o, 1'b1)
        `CHK({g2, g1}, 8'h99)
        chopper();
        zero_stop();
        for (int i = 0; i < 8; i++) begin
            step_chk(1'b1, 1'b1, 1'b1);
        end
        step_chk(1'b1, 1'b0, 1'b1);
        step_chk(1'b1, 1'b0, 1'b1);
        step_chk(1'b0, 1'b0, 1'b1);
        step_chk(1'b0, 1'b1, 1'b1);
        dir_r = 1'b1;
        cyc(10);
        dir_r = 1'b0;
        cyc(10);
        `CHK(pos_o, pos)
        gating();
        chip_reset();
        slow_chop();
        close_out();
    end

    // Whole sequence needs about 5,200 clocks
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule
